// ==== verilog/tac_top.sv ====
// Traffic announcement and traffic program flag control
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
module tac_top
	import tac_pkg::*;
#(
	parameter int TEXT_ALIGN_CYCLES = TEXT_ALIGN_CYC  // Text alignment wait
)
(
	input  wire logic        REF_CLK,       // 125 MHz clock
	input  wire logic        RST,           // Async reset, high
	input  wire logic [3:0]  ADDR,          // Register address
	input  wire logic [31:0] WDATA,         // Write data
	input  wire logic        WR,            // Write strobe
	input  wire logic        RD,            // Read strobe
	output logic      [31:0] RDATA,         // Read data, cycle after RD
	input  wire logic        MINUTE_TICK,   // RTC minute pulse
	input  wire logic        TA_SWITCH_N,   // Announce switch, low active
	input  wire logic        LTA_SWITCH_N,  // Linked-station switch, low active
	input  wire logic        EON_ACTIVE,    // Other network announcing
	output logic             TRAFFIC_ANNOUNCE_FLAG,        // Announce flag
	output logic             TRAFFIC_PROGRAM_FLAG,         // Program flag
	output logic             LINKED_STATION_ANNOUNCE_FLAG, // Linked-station flag
	output logic      [63:0] TRAFFIC_NAME_TEXT,            // Name text, 8 chars
	output logic             TRAFFIC_NAME_ENABLE           // Name text sent
);

	//=====================================================================
	// Register state
	logic        tp_q;
	logic        cmd_ta_q;
	logic        eon_en_q;
	logic        cmd_lta_q;
	logic [7:0]  tmo_q;
	logic [63:0] text_q;
	logic [63:0] text_pend_q;
	logic [3:0]  text_len_q;
	logic [3:0]  text_len_pend_q;
	logic        align_q;
	logic [31:0] align_cnt_q;
	logic        sw_ta_q;
	logic [6:0]  min_cnt_q;
	logic [31:0] rdata_q;

	//=====================================================================
	// Switch inputs
	logic ta_level;
	logic ta_rise;
	logic ta_fall;
	logic lta_level;

	tac_switch_sync u_ta_sync
	(
		.clk   (REF_CLK),
		.rst   (RST),
		.din   (TA_SWITCH_N),
		.level (ta_level),
		.rise  (ta_rise),
		.fall  (ta_fall)
	);

	tac_switch_sync u_lta_sync
	(
		.clk   (REF_CLK),
		.rst   (RST),
		.din   (LTA_SWITCH_N),
		.level (lta_level),
		.rise  (),
		.fall  ()
	);

	//=====================================================================
	// Decode
	wire wr_ctrl    = WR && (ADDR == TAC_REG_CTRL);
	wire wr_tmo     = WR && (ADDR == TAC_REG_TIMEOUT);
	wire wr_text_lo = WR && (ADDR == TAC_REG_TEXT_LO);
	wire wr_text_hi = WR && (ADDR == TAC_REG_TEXT_HI);
	wire wr_len     = WR && (ADDR == TAC_REG_TEXT_LEN);
	wire wr_init    = WR && (ADDR == TAC_REG_INIT) && (WDATA[7:0] == TAC_INIT_KEY);

	wire [6:0] tmo_minutes = tmo_q[6:0];
	wire       tmo_edge    = tmo_q[TAC_TMO_EDGE_BIT];
	wire       timed_mode  = (tmo_minutes != 7'h00);
	wire       expire      = timed_mode && sw_ta_q && MINUTE_TICK
		&& (min_cnt_q + 7'h01 >= tmo_minutes);
	wire [3:0] len_clip    = (WDATA[3:0] > 4'h8) ? 4'h8 : WDATA[3:0];

	//=====================================================================
	// Control registers
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			tp_q      <= TAC_TP_RST;
			cmd_ta_q  <= 1'b0;
			eon_en_q  <= 1'b0;
			cmd_lta_q <= 1'b0;
			tmo_q     <= TAC_TIMEOUT_RST;
		end
		else if (wr_init)
		begin
			tp_q      <= TAC_TP_RST;
			cmd_ta_q  <= 1'b0;
			eon_en_q  <= 1'b0;
			cmd_lta_q <= 1'b0;
			tmo_q     <= TAC_TIMEOUT_RST;
		end
		else
		begin
			if (wr_ctrl)
			begin
				tp_q      <= WDATA[TAC_CTRL_TP_BIT];
				cmd_ta_q  <= WDATA[TAC_CTRL_TA_BIT];
				eon_en_q  <= WDATA[TAC_CTRL_EON_BIT];
				cmd_lta_q <= WDATA[TAC_CTRL_LTA_BIT];
			end
			if (!(wr_ctrl ? WDATA[TAC_CTRL_TP_BIT] : tp_q))
				tmo_q <= 8'h00;
			else if (wr_tmo)
				tmo_q <= WDATA[7:0];
		end
	end

	//=====================================================================
	// Switch-driven announce flag and minute counter
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			sw_ta_q   <= 1'b0;
			min_cnt_q <= 7'h00;
		end
		else if (!timed_mode)
		begin
			sw_ta_q   <= ~ta_level;
			min_cnt_q <= 7'h00;
		end
		else if (expire)
		begin
			sw_ta_q   <= 1'b0;
			min_cnt_q <= 7'h00;
		end
		else if (ta_fall)
		begin
			sw_ta_q   <= 1'b1;
			min_cnt_q <= 7'h00;
		end
		else if (ta_rise && tmo_edge)
		begin
			sw_ta_q   <= 1'b0;
			min_cnt_q <= 7'h00;
		end
		else if (sw_ta_q && MINUTE_TICK)
			min_cnt_q <= min_cnt_q + 7'h01;
	end

	//=====================================================================
	// Traffic name text with group alignment delay
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			text_q          <= 64'h0;
			text_pend_q     <= 64'h0;
			text_len_q      <= TAC_TEXT_LEN_RST;
			text_len_pend_q <= TAC_TEXT_LEN_RST;
			align_q         <= 1'b0;
			align_cnt_q     <= 32'h0;
		end
		else if (wr_init)
		begin
			text_len_q      <= TAC_TEXT_LEN_RST;
			text_len_pend_q <= TAC_TEXT_LEN_RST;
			align_q         <= 1'b0;
			align_cnt_q     <= 32'h0;
		end
		else
		begin
			if (wr_text_lo)
				text_pend_q[31:0] <= WDATA;
			if (wr_text_hi)
				text_pend_q[63:32] <= WDATA;
			if (wr_len)
			begin
				text_len_pend_q <= len_clip;
				align_q         <= 1'b1;
				align_cnt_q     <= 32'h0;
			end
			else if (align_q)
			begin
				if (align_cnt_q + 32'h1 >= 32'(TEXT_ALIGN_CYCLES))
				begin
					align_q    <= 1'b0;
					text_q     <= text_pend_q;
					text_len_q <= text_len_pend_q;
				end
				else
					align_cnt_q <= align_cnt_q + 32'h1;
			end
		end
	end

	//=====================================================================
	// Read port
	always_comb
	begin
		unique case (ADDR)
			TAC_REG_CTRL:     rdata_q = {28'h0, cmd_lta_q, eon_en_q, cmd_ta_q, tp_q};
			TAC_REG_TIMEOUT:  rdata_q = {24'h0, tmo_q};
			TAC_REG_TEXT_LO:  rdata_q = text_pend_q[31:0];
			TAC_REG_TEXT_HI:  rdata_q = text_pend_q[63:32];
			TAC_REG_TEXT_LEN: rdata_q = {28'h0, text_len_q};
			TAC_REG_STATUS:   rdata_q = {27'h0, align_q, LINKED_STATION_ANNOUNCE_FLAG,
				sw_ta_q, TRAFFIC_ANNOUNCE_FLAG, TRAFFIC_PROGRAM_FLAG};
			default:          rdata_q = 32'h0;
		endcase
	end

	//=====================================================================
	// Outputs
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			RDATA                        <= 32'h0;
			TRAFFIC_ANNOUNCE_FLAG        <= 1'b0;
			TRAFFIC_PROGRAM_FLAG         <= 1'b0;
			LINKED_STATION_ANNOUNCE_FLAG <= 1'b0;
			TRAFFIC_NAME_TEXT            <= 64'h0;
			TRAFFIC_NAME_ENABLE          <= 1'b0;
		end
		else
		begin
			RDATA <= RD ? rdata_q : 32'h0;
			// Switch or command sets announce only with program flag; enabled other-network announce forces both
			TRAFFIC_ANNOUNCE_FLAG <= (tp_q | eon_en_q & EON_ACTIVE)
				& (sw_ta_q | cmd_ta_q | eon_en_q & EON_ACTIVE);
			TRAFFIC_PROGRAM_FLAG <= tp_q | (eon_en_q & EON_ACTIVE);
			LINKED_STATION_ANNOUNCE_FLAG <= ~lta_level | cmd_lta_q;
			TRAFFIC_NAME_TEXT   <= text_q;
			TRAFFIC_NAME_ENABLE <= (text_len_q != 4'h0);
		end
	end

endmodule : tac_top

// ==== verilog/tac_pkg.sv ====
// Constants and register map of the traffic announcement control block
//=====================================================================
package tac_pkg;

	//=====================================================================
	// Register offsets
	localparam logic [3:0] TAC_REG_CTRL    = 4'h0;
	localparam logic [3:0] TAC_REG_TIMEOUT = 4'h1;
	localparam logic [3:0] TAC_REG_TEXT_LO = 4'h2;
	localparam logic [3:0] TAC_REG_TEXT_HI = 4'h3;
	localparam logic [3:0] TAC_REG_TEXT_LEN = 4'h4;
	localparam logic [3:0] TAC_REG_STATUS  = 4'h5;
	localparam logic [3:0] TAC_REG_INIT    = 4'h6;

	//=====================================================================
	// Control fields
	localparam int TAC_CTRL_TP_BIT   = 0;
	localparam int TAC_CTRL_TA_BIT   = 1;
	localparam int TAC_CTRL_EON_BIT  = 2;
	localparam int TAC_CTRL_LTA_BIT  = 3;
	localparam int TAC_TMO_EDGE_BIT  = 7;
	localparam int TAC_STAT_BUSY_BIT = 4;

	//=====================================================================
	// Reset values and sizes
	localparam int         TAC_TEXT_CHARS  = 8;
	localparam logic [7:0] TAC_TIMEOUT_RST = 8'h00;
	localparam logic       TAC_TP_RST      = 1'b0;
	localparam logic [3:0] TAC_TEXT_LEN_RST = 4'h0;
	localparam logic [7:0] TAC_INIT_KEY    = 8'hA5;

	//=====================================================================
	// Timing
	localparam int CLK_HZ        = 125_000_000;
	localparam int TEXT_ALIGN_MS = 400;
	localparam int TEXT_ALIGN_CYC = TEXT_ALIGN_MS * (CLK_HZ / 1000);

endpackage : tac_pkg

// ==== verilog/tac_switch_sync.sv ====
// Synchroniser and edge detector for one switch input
`timescale 1ns/100ps
module tac_switch_sync
(
	input  wire logic clk,      // Clock
	input  wire logic rst,      // Async reset, high
	input  wire logic din,      // Raw switch level
	output logic      level,    // Synchronised level
	output logic      rise,     // Rising edge pulse
	output logic      fall      // Falling edge pulse
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// Idle high: open input reads as inactive
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end
		else
		begin
			meta_q <= din;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;

endmodule : tac_switch_sync

// ==== test/tac_chk.sv ====
// Port-level checks of the traffic announcement control block
`timescale 1ns/100ps
module tac_chk
	import tac_pkg::*;
#(
	parameter int TEXT_ALIGN_CYCLES = 8  // Text alignment wait
)
(
	input wire logic        REF_CLK,                      // Clock
	input wire logic        RST,                          // Reset
	input wire logic [3:0]  ADDR,                         // Address
	input wire logic [31:0] WDATA,                        // Write data
	input wire logic        WR,                           // Write strobe
	input wire logic        MINUTE_TICK,                  // Minute pulse
	input wire logic        TA_SWITCH_N,                  // Announce switch
	input wire logic        LTA_SWITCH_N,                 // Linked switch
	input wire logic        EON_ACTIVE,                   // Other network
	input wire logic        TRAFFIC_ANNOUNCE_FLAG,        // Announce flag
	input wire logic        TRAFFIC_PROGRAM_FLAG,         // Program flag
	input wire logic        LINKED_STATION_ANNOUNCE_FLAG  // Linked flag
);
	//=====================================================================
	// Shadow of the timeout setting
	logic [7:0] tmo_q;
	wire        ctrl_wr = WR && ADDR == TAC_REG_CTRL;
	wire        timed   = tmo_q[6:0] != 7'h00 && TRAFFIC_PROGRAM_FLAG && !EON_ACTIVE;
	always_ff @(posedge REF_CLK or posedge RST)
		if (RST)
			tmo_q <= 8'h00;
		else if (!TRAFFIC_PROGRAM_FLAG)
			tmo_q <= 8'h00;
		else if (WR && ADDR == TAC_REG_TIMEOUT)
			tmo_q <= WDATA[7:0];
	//=====================================================================
	// Assertions
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	a_tp_write: assert property (ctrl_wr |-> ##2 TRAFFIC_PROGRAM_FLAG == $past(WDATA[0], 2))
		else $error("program flag differs from written bit");
	a_ta_gated: assert property ((!TRAFFIC_PROGRAM_FLAG && !EON_ACTIVE)[*5] |-> !TRAFFIC_ANNOUNCE_FLAG)
		else $error("announce flag set without program flag");
	a_lta_level: assert property ((!LTA_SWITCH_N)[*4] |-> LINKED_STATION_ANNOUNCE_FLAG)
		else $error("linked flag not following its switch");
	a_level_set: assert property ((tmo_q == 8'h00 && TRAFFIC_PROGRAM_FLAG && !TA_SWITCH_N)[*5]
		|-> TRAFFIC_ANNOUNCE_FLAG)
		else $error("low switch level did not set announce flag");
	a_level_clear: assert property ((tmo_q == 8'h00 && !EON_ACTIVE && TA_SWITCH_N)[*5]
		|-> !TRAFFIC_ANNOUNCE_FLAG)
		else $error("high switch level did not clear announce flag");
	a_fall_set: assert property (timed && $fell(TA_SWITCH_N) |-> ##[1:6] TRAFFIC_ANNOUNCE_FLAG)
		else $error("falling switch edge did not set announce flag");
	a_edge_clear: assert property (timed && tmo_q[7] && $rose(TA_SWITCH_N)
		|-> ##[1:6] !TRAFFIC_ANNOUNCE_FLAG)
		else $error("rising switch edge did not clear announce flag");
	a_tick_expiry: assert property (timed && !tmo_q[7] && $fell(TRAFFIC_ANNOUNCE_FLAG)
		|-> $past(MINUTE_TICK) || $past(MINUTE_TICK, 2) || $past(MINUTE_TICK, 3) || $past(WR, 3))
		else $error("announce flag cleared off a minute tick");
endmodule : tac_chk

// ==== test/tac_far.sv ====
// Model of the traffic switches and the minute clock
`timescale 1ns/100ps
module tac_far
(
	input  wire logic clk,         // Clock
	output logic      ta_sw_n,     // Announce switch
	output logic      lta_sw_n,    // Linked switch
	output logic      minute_tick  // Minute pulse
);
	// Open switches read high
	initial
	begin
		ta_sw_n     = 1'b1;
		lta_sw_n    = 1'b1;
		minute_tick = 1'b0;
	end
	task automatic set_ta(input logic v);
		@(posedge clk);
		ta_sw_n <= v;
	endtask : set_ta
	task automatic set_lta(input logic v);
		@(posedge clk);
		lta_sw_n <= v;
	endtask : set_lta
	task automatic tick();
		@(posedge clk);
		minute_tick <= 1'b1;
		@(posedge clk);
		minute_tick <= 1'b0;
	endtask : tick
endmodule : tac_far

// ==== test/tb_tac_top.sv ====
// Directed bench for the traffic announcement control block
`timescale 1ns/100ps
module tb_tac_top
	import tac_pkg::*;
;
	localparam int ALIGN = 8;
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic [3:0]  addr    = 4'h0;
	logic [31:0] wdata   = 32'h00000000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        eon_act = 1'b0;
	logic [31:0] rdata;
	logic [63:0] txt;
	logic        ta_n, lta_n, tick, ta_f, tp_f, lta_f, txt_en;
	int          bad_count  = 0;
	int          num_checks = 0;
	always #4 ref_clk = ~ref_clk;
	tac_far tac_far_i (.clk(ref_clk), .ta_sw_n(ta_n), .lta_sw_n(lta_n), .minute_tick(tick));
	tac_top #(.TEXT_ALIGN_CYCLES(ALIGN)) tac_top_i
	(
		.REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .MINUTE_TICK(tick), .TA_SWITCH_N(ta_n), .LTA_SWITCH_N(lta_n),
		.EON_ACTIVE(eon_act), .TRAFFIC_ANNOUNCE_FLAG(ta_f), .TRAFFIC_PROGRAM_FLAG(tp_f),
		.LINKED_STATION_ANNOUNCE_FLAG(lta_f), .TRAFFIC_NAME_TEXT(txt),
		.TRAFFIC_NAME_ENABLE(txt_en)
	);
	//=====================================================================
	// Access and compare tasks
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk("read data", 64'(rdata), 64'(exp));
	endtask : rd_reg
	task automatic sw_step(input logic v, input logic exp);
		tac_far_i.set_ta(v);
		cyc(6);
		chk("announce", 64'(ta_f), 64'(exp));
	endtask : sw_step
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	//=====================================================================
	// Tests
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(1);
		chk("announce", 64'(ta_f), 64'(0));
		wr_reg(TAC_REG_TIMEOUT, 32'h00000005);
		rd_reg(TAC_REG_TIMEOUT, 32'h00000000);
		rd_reg(4'hF, 32'h00000000);
		wr_reg(TAC_REG_CTRL, 32'h00000001);
		cyc(2);
		chk("program", 64'(tp_f), 64'(1));
		sw_step(1'b0, 1'b1);
		sw_step(1'b1, 1'b0);
		wr_reg(TAC_REG_TIMEOUT, 32'h00000002);
		rd_reg(TAC_REG_TIMEOUT, 32'h00000002);
		rd_reg(TAC_REG_CTRL, 32'h00000001);
		tac_far_i.set_lta(1'b0);
		cyc(6);
		chk("linked", 64'(lta_f), 64'(1));
		sw_step(1'b0, 1'b1);
		sw_step(1'b1, 1'b1);
		tac_far_i.tick();
		cyc(6);
		chk("announce", 64'(ta_f), 64'(1));
		tac_far_i.tick();
		cyc(4);
		chk("announce", 64'(ta_f), 64'(0));
		wr_reg(TAC_REG_TIMEOUT, 32'h00000083);
		rd_reg(TAC_REG_TIMEOUT, 32'h00000083);
		sw_step(1'b0, 1'b1);
		sw_step(1'b1, 1'b0);
		tac_far_i.set_lta(1'b1);
		cyc(6);
		chk("linked", 64'(lta_f), 64'(0));
		wr_reg(TAC_REG_TEXT_LO, 32'h41525446);
		wr_reg(TAC_REG_TEXT_HI, 32'h20434946);
		wr_reg(TAC_REG_TEXT_LEN, 32'h00000008);
		cyc(2);
		chk("name enable", 64'(txt_en), 64'(0));
		cyc(ALIGN + 2);
		chk("name enable", 64'(txt_en), 64'(1));
		chk("name text", txt, 64'h2043494641525446);
		wr_reg(TAC_REG_TEXT_LEN, 32'h00000000);
		cyc(ALIGN + 4);
		chk("name enable", 64'(txt_en), 64'(0));
		wr_reg(TAC_REG_TEXT_LEN, 32'h00000008);
		cyc(ALIGN + 4);
		wr_reg(TAC_REG_INIT, 32'h00000000);
		cyc(2);
		chk("program", 64'(tp_f), 64'(1));
		wr_reg(TAC_REG_INIT, {24'h000000, TAC_INIT_KEY});
		cyc(ALIGN + 4);
		chk("program", 64'(tp_f), 64'(0));
		chk("name enable", 64'(txt_en), 64'(0));
		wr_reg(TAC_REG_CTRL, 32'h00000004);
		cyc(2);
		@(posedge ref_clk);
		eon_act <= 1'b1;
		cyc(6);
		chk("announce", 64'(ta_f), 64'(1));
		@(posedge ref_clk);
		eon_act <= 1'b0;
		cyc(6);
		chk("announce", 64'(ta_f), 64'(0));
		wrap_up();
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		wrap_up();
	end
endmodule : tb_tac_top
bind tac_top tac_chk #(.TEXT_ALIGN_CYCLES(TEXT_ALIGN_CYCLES)) tac_chk_i
(
	.REF_CLK, .RST, .ADDR, .WDATA, .WR, .MINUTE_TICK, .TA_SWITCH_N, .LTA_SWITCH_N,
	.EON_ACTIVE, .TRAFFIC_ANNOUNCE_FLAG, .TRAFFIC_PROGRAM_FLAG, .LINKED_STATION_ANNOUNCE_FLAG
);
